// >>> logic/cfc_pkg.sv
package cfc_pkg;
   // ************************************************************
   // register map (byte-wide registers, plain port)
   // ************************************************************
   localparam logic [7:0] PLL_CTL_ADDR = 8'h1f;
   localparam logic [7:0] FWD_MAP_ADDR = 8'h20;
   localparam logic [7:0] FWD_MODE_ADDR = 8'h21;
   localparam logic [7:0] FWD_STAT_ADDR = 8'h22;

   // field positions
   localparam int OSC_SEL_BIT = 3;
   localparam int HALF_CLK_BIT = 2;
   localparam int RATE_LSB = 0;
   localparam int DIS_LSB = 4;
   localparam int MAP_LSB = 0;
   localparam int ASAP_BIT = 6;
   localparam int SYNC_LSB = 2;
   localparam int RR_BIT = 0;

   // reset values
   localparam logic [7:0] PLL_CTL_RST = 8'h02;
   localparam logic [7:0] FWD_MAP_RST = 8'hf0;
   localparam logic [7:0] FWD_MODE_RST = 8'h03;

   // lane rate and sync mode codes
   localparam logic [1:0] RATE_400M = 2'h3;
   localparam logic [1:0] SYNC_OFF = 2'h0;
   localparam logic [1:0] SYNC_CONCAT = 2'h3;

   localparam int NUM_PORTS = 4;
   localparam int DATA_W = 32;
endpackage

// >>> logic/cfc_skid_buf.sv
// two-entry buffer: full rate, and a receiver stall loses no word
module cfc_skid_buf
#(
   parameter int WIDTH = 32
)
(
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]      head;
      logic [1:0]            cnt;
      logic                  rdPtr;
      logic                  wrPtr;
      logic                  vld;
   } cfc_buf_t;

   cfc_buf_t s_q;
   cfc_buf_t s_d;

   // ************************************************************
   // storage
   // ************************************************************
   always_comb
   begin
      s_d = s_q;
      if (inValid && inReady)
      begin
         s_d.mem[s_q.wrPtr] = inData;
         s_d.wrPtr = ~s_q.wrPtr;
      end
      if (outValid && outReady)
         s_d.rdPtr = ~s_q.rdPtr;
      s_d.cnt = s_q.cnt + 2'(inValid && inReady) - 2'(outValid && outReady);
      // head word and valid live in flops, so the outputs leave straight from registers
      s_d.head = s_d.mem[s_d.rdPtr];
      s_d.vld  = (s_d.cnt != 2'h0);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign inReady  = (s_q.cnt != 2'h2);
   assign outValid = s_q.vld;
   assign outData  = s_q.head;
endmodule

// >>> logic/cfc_forward_ctrl.sv
// Function
// - oscillator bit picks external or internal reference
// - half-rate bit makes logic clock 100 MHz
// - two-bit lane rate select, resets to 10
// - per-port forward disable bits, reset to one
// - per-port output map bit, resets to zero
// - sync mode waits for all enabled ports
// - send-when-ready forwards each line when available
// - send-when-ready ignored in concatenation, short packets
// - two-bit sync mode field, resets to 00
// - best-effort bit serves ready ports round-robin
//
// Implementation choice: the strobed register port.
module cfc_forward_ctrl
   import cfc_pkg::*;
#(
   parameter int NPORT = cfc_pkg::NUM_PORTS,
   parameter int DW    = cfc_pkg::DATA_W
)
(
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   // register port
   input  wire logic [7:0]            regAddr,
   input  wire logic [7:0]            regWrData,
   input  wire logic                  regWrite,
   input  wire logic                  regRead,
   output logic      [7:0]            regRdData,
   // clocking controls
   output logic                       internalOscSelect,
   output logic                       halfRateClock,
   output logic      [1:0]            txLaneRate,
   // receive port streams
   input  wire logic [NPORT-1:0][DW-1:0] rxData,
   input  wire logic [NPORT-1:0]      rxValid,
   input  wire logic [NPORT-1:0]      rxLong,
   output logic      [NPORT-1:0]      rxReady,
   // forwarded stream toward the transmitter
   output logic      [DW-1:0]         txData,
   output logic      [1:0]            txPort,
   output logic                       txOutPort,
   output logic                       txValid,
   input  wire logic                  txReady
);
   typedef struct packed {
      logic [7:0]       pllCtl;
      logic [7:0]       fwdMap;
      logic [7:0]       fwdMode;
      logic [7:0]       rdData;
      logic [1:0]       rrPtr;
      logic [NPORT-1:0] sentMask;
      logic             synced;
   } cfc_state_t;

   cfc_state_t s_q;
   cfc_state_t s_d;

   logic [NPORT-1:0] enabled;
   logic [NPORT-1:0] eligible;
   logic             bufReady;
   logic             grantValid;
   logic [1:0]       grantIdx;
   logic [1:0]       syncMode;
   logic             asap;
   logic             allReady;
   logic [1:0]       idx;
   logic             found;
   logic [DW+3-1:0]  bufIn;
   logic [DW+3-1:0]  bufOut;

   // ************************************************************
   // eligibility
   // ************************************************************
   // asap is forced off in concatenation so lines stay glued together
   always_comb
   begin
      syncMode = s_q.fwdMode[SYNC_LSB +: 2];
      enabled  = ~s_q.fwdMap[DIS_LSB +: NPORT];
      asap     = s_q.fwdMode[ASAP_BIT] && (syncMode != SYNC_CONCAT);
      allReady = ((rxValid | s_q.sentMask | ~enabled) == '1);
      for (int p = 0; p < NPORT; p++)
      begin
         if (!enabled[p] || s_q.sentMask[p])
            eligible[p] = 1'b0;
         else if (syncMode == SYNC_OFF)
            eligible[p] = rxValid[p] && s_q.fwdMode[RR_BIT];
         else if (!rxLong[p])
            eligible[p] = rxValid[p];  // short packets never gated by asap
         else if (asap)
            eligible[p] = rxValid[p];
         else
            eligible[p] = rxValid[p] && allReady;
      end
   end

   // ************************************************************
   // round-robin pick starting after the last winner
   // ************************************************************
   always_comb
   begin
      found    = 1'b0;
      grantIdx = 2'h0;
      for (int k = 1; k <= NPORT; k++)
      begin
         idx = 2'(int'(s_q.rrPtr) + k);
         if (!found && eligible[idx])
         begin
            found    = 1'b1;
            grantIdx = idx;
         end
      end
      grantValid = found;
   end

   // only the granted port is drained, and only when the buffer has room
   always_comb
   begin
      rxReady = '0;
      if (grantValid && bufReady)
         rxReady[grantIdx] = 1'b1;
   end

   assign bufIn = {s_q.fwdMap[MAP_LSB + 32'(grantIdx)], grantIdx, rxData[grantIdx]};

   // ************************************************************
   // register and engine state update
   // ************************************************************
   always_comb
   begin
      s_d = s_q;
      if (regWrite)
      begin
         unique case (regAddr)
            PLL_CTL_ADDR:  s_d.pllCtl = {4'h0, regWrData[3:0]};
            FWD_MAP_ADDR:  s_d.fwdMap = regWrData;
            FWD_MODE_ADDR: s_d.fwdMode = {regWrData[7:4], regWrData[3:2], regWrData[1:0]};
            default:       s_d.fwdMode = s_q.fwdMode;
         endcase
      end
      // unmapped addresses read as zero
      s_d.rdData = 8'h00;
      if (regRead)
      begin
         unique case (regAddr)
            PLL_CTL_ADDR:  s_d.rdData = s_q.pllCtl;
            FWD_MAP_ADDR:  s_d.rdData = s_q.fwdMap;
            FWD_MODE_ADDR: s_d.rdData = s_q.fwdMode;
            FWD_STAT_ADDR: s_d.rdData = {7'h00, s_q.synced};
            default:       s_d.rdData = 8'h00;
         endcase
      end
      // sync round bookkeeping: a port sends one long line per round
      if (grantValid && bufReady)
      begin
         s_d.rrPtr = grantIdx;
         if (syncMode != SYNC_OFF && rxLong[grantIdx] && !asap)
            s_d.sentMask[grantIdx] = 1'b1;
         if (syncMode != SYNC_OFF && rxLong[grantIdx] && !asap && allReady)
            s_d.synced = 1'b1;
      end
      if ((s_d.sentMask | ~enabled) == '1 || syncMode == SYNC_OFF || asap)
         s_d.sentMask = '0;
      if (syncMode == SYNC_OFF)
         s_d.synced = 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         s_q          <= '0;
         s_q.pllCtl   <= PLL_CTL_RST;
         s_q.fwdMap   <= FWD_MAP_RST;
         s_q.fwdMode  <= FWD_MODE_RST;
      end
      else
         s_q <= s_d;
   end

   // ************************************************************
   // output buffer and register-driven controls
   // ************************************************************
   cfc_skid_buf #(.WIDTH(DW + 3)) outBuf
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .inData   (bufIn),
      .inValid  (grantValid),
      .inReady  (bufReady),
      .outData  (bufOut),
      .outValid (txValid),
      .outReady (txReady)
   );

   assign txData            = bufOut[DW-1:0];
   assign txPort            = bufOut[DW +: 2];
   assign txOutPort         = bufOut[DW + 2];
   assign internalOscSelect = s_q.pllCtl[OSC_SEL_BIT];
   assign halfRateClock     = s_q.pllCtl[HALF_CLK_BIT];
   assign txLaneRate        = s_q.pllCtl[RATE_LSB +: 2];
   assign regRdData         = s_q.rdData;
endmodule

// >>> verification/cfc_forward_ctrl_chk.sv
module cfc_forward_ctrl_chk
   import cfc_pkg::*;
#(parameter int NPORT = 4, parameter int DW = 32)
(
   input wire logic             core_clk,
   input wire logic             sys_rst,
   input wire logic [7:0]       regAddr,
   input wire logic [7:0]       regWrData,
   input wire logic             regWrite,
   input wire logic             regRead,
   input wire logic [7:0]       regRdData,
   input wire logic             internalOscSelect,
   input wire logic             halfRateClock,
   input wire logic [1:0]       txLaneRate,
   input wire logic [NPORT-1:0] rxValid,
   input wire logic [NPORT-1:0] rxReady,
   input wire logic [DW-1:0]    txData,
   input wire logic [1:0]       txPort,
   input wire logic             txOutPort,
   input wire logic             txValid,
   input wire logic             txReady
);
   // ************************************************************
   // port map shadow and assertions
   // ************************************************************
   logic [7:0] map_q;
   logic       pllWr;
   assign pllWr = regWrite && regAddr == PLL_CTL_ADDR;
   // shadow copy, so disable and map checks need no internal probes
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         map_q <= FWD_MAP_RST;
      else if (regWrite && regAddr == FWD_MAP_ADDR)
         map_q <= regWrData;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_pll; pllWr |=> {internalOscSelect, halfRateClock, txLaneRate} == $past(regWrData[3:0]); endproperty
   a_pll: assert property (p_pll) else $error("clock control");
   property p_rdz; !$past(regRead) |-> regRdData == 8'h00; endproperty
   a_rdz: assert property (p_rdz) else $error("read data");
   property p_dis; (rxReady & map_q[7:4]) == 4'h0; endproperty
   a_dis: assert property (p_dis) else $error("disabled port");
   property p_one; $onehot0(rxReady); endproperty
   a_one: assert property (p_one) else $error("two grants");
   property p_vld; (rxReady & ~rxValid) == 4'h0; endproperty
   a_vld: assert property (p_vld) else $error("grant idle");
   property p_hold; txValid && !txReady |=> txValid && $stable(txData) && $stable(txPort); endproperty
   a_hold: assert property (p_hold) else $error("word dropped");
   property p_map; txValid |-> txOutPort == map_q[txPort]; endproperty
   a_map: assert property (p_map) else $error("map");
   property p_rst; $fell(sys_rst) |-> !txValid && rxReady == 4'h0; endproperty
   a_rst: assert property (p_rst) else $error("reset");
endmodule
bind cfc_forward_ctrl cfc_forward_ctrl_chk #(.NPORT(NPORT), .DW(DW)) u_cfc_forward_ctrl_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .internalOscSelect(internalOscSelect),
   .halfRateClock(halfRateClock), .txLaneRate(txLaneRate), .rxValid(rxValid), .rxReady(rxReady),
   .txData(txData), .txPort(txPort), .txOutPort(txOutPort), .txValid(txValid), .txReady(txReady));

// >>> verification/cfc_sink_model.sv
module cfc_sink_model
(
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic slowSink,
   output logic      txReady
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // downstream receiver
   // ************************************************************
   logic [1:0] tick_q;
   // one ready in four when slow, so the two-entry buffer fills up
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         tick_q <= 2'h0;
      else
         tick_q <= tick_q + 2'h1;
   end
   assign txReady = !slowSink || tick_q == 2'h3;
endmodule

// >>> verification/tb_top.sv
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("FAIL %0t got %h", $time, (a)); end end
module tb_top
   import cfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // stimulus and scenarios
   // ************************************************************
   logic                       core_clk = 1'b0;
   logic                       sys_rst = 1'b1;
   logic [7:0]                 regAddr = 8'h00;
   logic [7:0]                 regWrData = 8'h00;
   logic                       regWrite = 1'b0;
   logic                       regRead = 1'b0;
   logic [7:0]                 regRdData;
   logic                       internalOscSelect;
   logic                       halfRateClock;
   logic [1:0]                 txLaneRate;
   logic [3:0][31:0]           rxData;
   logic [3:0]                 rxValid = 4'hf;
   logic [3:0]                 rxLong = 4'hf;
   logic [3:0]                 rxReady;
   logic [31:0]                txData;
   logic [1:0]                 txPort;
   logic                       txOutPort;
   logic                       txValid;
   logic                       txReady;
   logic                       slowSink = 1'b0;
   int                         fails = 0;
   int                         comparisons = 0;
   cfc_forward_ctrl u_cfc_forward_ctrl (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .internalOscSelect(internalOscSelect), .halfRateClock(halfRateClock), .txLaneRate(txLaneRate),
      .rxData(rxData), .rxValid(rxValid), .rxLong(rxLong), .rxReady(rxReady), .txData(txData),
      .txPort(txPort), .txOutPort(txOutPort), .txValid(txValid), .txReady(txReady));
   cfc_sink_model u_cfc_sink_model (.core_clk(core_clk), .sys_rst(sys_rst), .slowSink(slowSink),
      .txReady(txReady));
   always #2.5 core_clk = ~core_clk;
   // write and read-compare cycles of the register port
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(negedge core_clk);
      `CHK(regRdData, e)
   endtask
   // counts accepted receive words over n cycles
   task automatic takes(input int n, output int k);
      k = 0;
      repeat (n)
      begin
         @(negedge core_clk);
         k += $countones(rxValid & rxReady);
      end
   endtask
   task automatic t_reset;
      rdc(PLL_CTL_ADDR, 8'h02);
      rdc(FWD_MAP_ADDR, 8'hf0);
      rdc(FWD_MODE_ADDR, 8'h03);
      rdc(8'h40, 8'h00);
      rdc(FWD_STAT_ADDR, 8'h00);
      `CHK(rxReady, 4'h0)
      $display("reset test done");
   endtask
   task automatic t_clock;
      logic [7:0] v;
      for (int i = 0; i < 4; i++)
      begin
         // half rate is left off while the lanes run at 400M
         v = {4'h0, i[0], i != 3, i[1:0]};
         wr(PLL_CTL_ADDR, v);
         rdc(PLL_CTL_ADDR, v);
         `CHK({internalOscSelect, halfRateClock, txLaneRate}, v[3:0])
      end
      wr(PLL_CTL_ADDR, 8'hf2);
      rdc(PLL_CTL_ADDR, 8'h02);
      $display("clock test done");
   endtask
   task automatic t_rr;
      logic [1:0] last;
      int n;
      @(posedge core_clk);
      slowSink <= 1'b1;
      wr(FWD_MAP_ADDR, 8'hfa);
      wr(FWD_MAP_ADDR, 8'h8a);
      n = 0;
      while (n < 7)
      begin
         @(negedge core_clk);
         if (txValid && txReady)
         begin
            `CHK(txData, 32'h00c0ffe0 + txPort)
            `CHK(txOutPort, txPort[0])
            if (n > 0) `CHK(txPort, last == 2'h2 ? 2'h0 : last + 2'h1)
            last = txPort;
            n++;
         end
      end
      wr(FWD_MAP_ADDR, 8'hfa);
      slowSink <= 1'b0;
      repeat (8) @(negedge core_clk);
      `CHK(txValid, 1'b0)
      $display("round robin test done");
   endtask
   task automatic t_sync;
      int k;
      wr(FWD_MODE_ADDR, 8'h00);
      wr(FWD_MAP_ADDR, 8'hc0);
      takes(12, k);
      `CHK(k, 0)
      @(posedge core_clk);
      rxValid <= 4'h1;
      wr(FWD_MODE_ADDR, 8'h04);
      takes(12, k);
      `CHK(k, 0)
      wr(FWD_MODE_ADDR, 8'h44);
      takes(12, k);
      `CHK(k > 0, 1'b1)
      wr(FWD_MODE_ADDR, 8'h4c);
      takes(12, k);
      `CHK(k, 0)
      @(posedge core_clk);
      rxLong <= 4'h0;
      takes(8, k);
      `CHK(k > 0, 1'b1)
      rdc(FWD_STAT_ADDR, 8'h00);
      @(posedge core_clk);
      rxLong <= 4'hf;
      rxValid <= 4'h3;
      wr(FWD_MODE_ADDR, 8'h08);
      takes(8, k);
      `CHK(k > 1, 1'b1)
      rdc(FWD_STAT_ADDR, 8'h01);
      $display("sync test done");
   endtask
   task automatic summarize;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // main sequence, under two thousand cycles
   initial
   begin
      for (int p = 0; p < NUM_PORTS; p++)
         rxData[p] = 32'h00c0ffe0 + p;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset;
      t_clock;
      t_rr;
      t_sync;
      summarize;
   end
   // watchdog, well beyond the expected run
   initial
   begin
      #50us;
      fails++;
      summarize;
   end
endmodule
